// File: src/tcc_pkg.sv
// Package for the tape character datapath checker: widths, timing counts and state codes.
// Assumes a 200 MHz system clock; only the datapath references names here, with full scope.
package tcc_pkg;

  localparam int unsigned CHAR_W = 7;

  localparam int unsigned CLK_PERIOD_NS = 5;

  // Nominal spacing between characters on tape and the capture window.
  localparam int unsigned CHAR_SPACING_NS = 2000;
  // A little less than half the spacing.
  localparam int unsigned ACCUM_WINDOW_NS = 900;
  localparam int unsigned ACCUM_CYC = (ACCUM_WINDOW_NS / CLK_PERIOD_NS > 0) ? ACCUM_WINDOW_NS / CLK_PERIOD_NS : 1;

  // Longitudinal sample delay after the check character is entered.
  localparam int unsigned LRC_SAMPLE_NS = 400;
  localparam int unsigned LRC_SAMPLE_CYC = (LRC_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Write cycle timing: pulse issue point and late echo sample point.
  localparam int unsigned WR_PULSE_NS = 100;
  localparam int unsigned WR_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_SAMPLE_NS = 1500;
  localparam int unsigned WR_SAMPLE_CYC = WR_SAMPLE_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 12;

  localparam logic [CHAR_W-1:0] CHAR_ZERO = 7'h00;

  typedef enum logic [3:0] {
    TCC_RD_IDLE   = 4'b0001,
    TCC_RD_ACCUM  = 4'b0010,
    TCC_RD_LRCWT  = 4'b0100,
    TCC_RD_SPARE  = 4'b1000
  } tcc_rd_state_e;

  typedef enum logic [2:0] {
    TCC_WR_IDLE  = 3'b001,
    TCC_WR_PULSE = 3'b010,
    TCC_WR_WAIT  = 3'b100
  } tcc_wr_state_e;

endpackage : tcc_pkg

// File: src/tcc_parity_tree.sv
// Vertical parity checker: pairwise exclusive-or tree over seven bit lines.
// Assumes bit 6 is the check bit; purely combinational.
`timescale 1ns/10ps
`default_nettype none

module tcc_parity_tree (
  input  wire logic [6:0] i_char,
  input  wire logic       i_odd_sense,
  output logic            o_err
);

  logic l1_a;
  logic l1_b;
  logic l1_c;
  logic check_in;
  logic l2_a;
  logic l2_b;

  // The sense flag conditions the check bit so one tree covers odd and even parity.
  assign check_in = i_char[6] ^ i_odd_sense;
  assign l1_a     = i_char[0] ^ i_char[1];
  assign l1_b     = i_char[2] ^ i_char[3];
  assign l1_c     = i_char[4] ^ i_char[5];
  assign l2_a     = l1_a ^ l1_b;
  assign l2_b     = l1_c ^ check_in;
  // Error when the sum disagrees with the selected sense.
  assign o_err    = l2_a ^ l2_b;

endmodule : tcc_parity_tree

`default_nettype wire

// File: src/tcc_datapath.sv
// Tape character datapath: capture registers, transfer register, parity, longitudinal and echo checks.
// Assumes all inputs synchronous to i_sys_clk; detector bits are one-cycle set pulses.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Two seven-bit capture registers, high and low.
// - Bits accumulate for slightly under half spacing.
// - Incomplete character at window end flags error.
// - Forward high register if parity good, else low.
// - Selected character also enters longitudinal register.
// - Read-back check feeds longitudinal register only.
// - Host write character loads transfer register, drives drive.
// - Read loads transfer register, presents to host.
// - Parity checkers on high capture and transfer.
// - Host sense flag selects odd or even.
// - Pairwise exclusive-or tree, sense on check bit.
// - Longitudinal stages clear at every read start.
// - Each one bit toggles its longitudinal stage.
// - Stage set after check character gives error.
// - Sample longitudinal register well after check character.
// - Set missing-echo flag before each write pulse.
// - Any echo pulse clears missing-echo flag, except in a write load cycle.
// - Late sample of missing echo sets errors.
module tcc_datapath #(
  parameter int unsigned ACCUM_CYC      = tcc_pkg::ACCUM_CYC,
  parameter int unsigned LRC_SAMPLE_CYC = tcc_pkg::LRC_SAMPLE_CYC,
  parameter int unsigned WR_PULSE_CYC   = tcc_pkg::WR_PULSE_CYC,
  parameter int unsigned WR_SAMPLE_CYC  = tcc_pkg::WR_SAMPLE_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_err_reset,
  input  wire logic       i_odd_sense,
  input  wire logic       i_read_start,
  input  wire logic       i_readback_mode,
  input  wire logic [6:0] i_hi_bits,
  input  wire logic [6:0] i_lo_bits,
  input  wire logic       i_check_char,
  input  wire logic       i_wr_char_valid,
  input  wire logic [6:0] i_wr_char,
  input  wire logic       i_echo,
  output logic [6:0]      o_rd_data,
  output logic            o_rd_valid,
  output logic [6:0]      o_wr_bus,
  output logic            o_wr_pulse,
  output logic [6:0]      o_lrc_stages,
  output logic            o_hi_parity_err,
  output logic            o_xfer_parity_err,
  output logic            o_read_cycle_err,
  output logic            o_lrc_err,
  output logic            o_missing_echo,
  output logic            o_echo_err,
  output logic            o_error
);

  localparam int unsigned CW = tcc_pkg::CHAR_W;
  localparam int unsigned NW = tcc_pkg::CNT_W;

  function automatic logic [NW-1:0] cnt_last(input int unsigned cycles);
    cnt_last = NW'(cycles - 1);
  endfunction : cnt_last

  tcc_pkg::tcc_rd_state_e rd_state_ff;
  tcc_pkg::tcc_rd_state_e nxt_rd_state;
  tcc_pkg::tcc_wr_state_e wr_state_ff;
  tcc_pkg::tcc_wr_state_e nxt_wr_state;

  logic [CW-1:0] hi_reg_ff;
  logic [CW-1:0] nxt_hi_reg;
  logic [CW-1:0] lo_reg_ff;
  logic [CW-1:0] nxt_lo_reg;
  logic [CW-1:0] xfer_ff;
  logic [CW-1:0] nxt_xfer;
  logic [CW-1:0] lrc_ff;
  logic [CW-1:0] nxt_lrc;
  logic [NW-1:0] rd_cnt_ff;
  logic [NW-1:0] nxt_rd_cnt;
  logic [NW-1:0] wr_cnt_ff;
  logic [NW-1:0] nxt_wr_cnt;
  logic          is_check_ff;
  logic          nxt_is_check;
  logic          rd_valid_ff;
  logic          nxt_rd_valid;
  logic          wr_pulse_ff;
  logic          nxt_wr_pulse;
  logic          miss_echo_ff;
  logic          nxt_miss_echo;
  logic          hi_perr_ff;
  logic          nxt_hi_perr;
  logic          x_perr_ff;
  logic          nxt_x_perr;
  logic          rc_err_ff;
  logic          nxt_rc_err;
  logic          lrc_err_ff;
  logic          nxt_lrc_err;
  logic          echo_err_ff;
  logic          nxt_echo_err;
  logic          error_ff;
  logic          nxt_error;

  logic          hi_bad;
  logic          xfer_bad;
  logic [CW-1:0] sel_char;
  logic          window_end;
  logic          incomplete;

  tcc_parity_tree u_hi_parity (
    .i_char      (hi_reg_ff),
    .i_odd_sense (i_odd_sense),
    .o_err       (hi_bad)
  );

  tcc_parity_tree u_xfer_parity (
    .i_char      (xfer_ff),
    .i_odd_sense (i_odd_sense),
    .o_err       (xfer_bad)
  );

  // A character is taken as complete when both detector levels saw the same bits;
  // a low-only bit means the high level never caught up within the window.
  assign window_end = (rd_state_ff == tcc_pkg::TCC_RD_ACCUM) && (rd_cnt_ff == cnt_last(ACCUM_CYC));
  assign incomplete = (hi_reg_ff != lo_reg_ff);
  assign sel_char   = hi_bad ? lo_reg_ff : hi_reg_ff;

  // Read side state.
  always_comb begin
    nxt_rd_state  = rd_state_ff;
    nxt_rd_cnt    = rd_cnt_ff;
    nxt_hi_reg    = hi_reg_ff;
    nxt_lo_reg    = lo_reg_ff;
    nxt_lrc       = lrc_ff;
    nxt_is_check  = is_check_ff;
    nxt_rd_valid  = 1'b0;
    // Clearing first lets an error raised in the reset cycle survive it.
    nxt_hi_perr   = hi_perr_ff && !i_err_reset;
    nxt_rc_err    = rc_err_ff && !i_err_reset;
    nxt_lrc_err   = lrc_err_ff && !i_err_reset;
    if (i_read_start) begin
      nxt_lrc      = tcc_pkg::CHAR_ZERO;
      nxt_rd_state = tcc_pkg::TCC_RD_IDLE;
      nxt_hi_reg   = tcc_pkg::CHAR_ZERO;
      nxt_lo_reg   = tcc_pkg::CHAR_ZERO;
    end else begin
      unique case (rd_state_ff)
        tcc_pkg::TCC_RD_IDLE: begin
          // The first arriving bit opens the capture window.
          if ((i_hi_bits | i_lo_bits) != tcc_pkg::CHAR_ZERO) begin
            nxt_hi_reg   = i_hi_bits;
            nxt_lo_reg   = i_lo_bits;
            nxt_is_check = i_check_char;
            nxt_rd_cnt   = '0;
            nxt_rd_state = tcc_pkg::TCC_RD_ACCUM;
          end
        end
        tcc_pkg::TCC_RD_ACCUM: begin
          nxt_hi_reg   = hi_reg_ff | i_hi_bits;
          nxt_lo_reg   = lo_reg_ff | i_lo_bits;
          nxt_is_check = is_check_ff | i_check_char;
          nxt_rd_cnt   = rd_cnt_ff + NW'(1);
          if (window_end) begin
            if (incomplete) begin
              nxt_rc_err = 1'b1;
            end
            if (hi_bad) begin
              nxt_hi_perr = 1'b1;
            end
            nxt_lrc      = lrc_ff ^ sel_char;
            nxt_rd_valid = !i_readback_mode;
            nxt_hi_reg   = tcc_pkg::CHAR_ZERO;
            nxt_lo_reg   = tcc_pkg::CHAR_ZERO;
            nxt_rd_cnt   = '0;
            nxt_rd_state = is_check_ff ? tcc_pkg::TCC_RD_LRCWT : tcc_pkg::TCC_RD_IDLE;
          end
        end
        tcc_pkg::TCC_RD_LRCWT: begin
          // Sampling late lets the last character settle into the stages first.
          nxt_rd_cnt = rd_cnt_ff + NW'(1);
          if (rd_cnt_ff == cnt_last(LRC_SAMPLE_CYC)) begin
            if (lrc_ff != tcc_pkg::CHAR_ZERO) begin
              nxt_lrc_err = 1'b1;
            end
            nxt_is_check = 1'b0;
            nxt_rd_state = tcc_pkg::TCC_RD_IDLE;
          end
        end
        default: begin
          nxt_rd_state = tcc_pkg::TCC_RD_IDLE;
        end
      endcase
    end
  end

  // Write side state and the shared transfer register.
  always_comb begin
    nxt_wr_state  = wr_state_ff;
    nxt_wr_cnt    = wr_cnt_ff;
    nxt_wr_pulse  = 1'b0;
    nxt_miss_echo = miss_echo_ff;
    nxt_echo_err  = echo_err_ff && !i_err_reset;
    nxt_xfer      = xfer_ff;
    nxt_x_perr    = x_perr_ff && !i_err_reset;
    if (window_end && !i_readback_mode && !i_read_start) begin
      nxt_xfer = sel_char;
    end
    if (i_echo) begin
      nxt_miss_echo = 1'b0;
    end
    unique case (wr_state_ff)
      tcc_pkg::TCC_WR_IDLE: begin
        if (i_wr_char_valid) begin
          nxt_xfer      = i_wr_char;
          nxt_miss_echo = 1'b1;
          nxt_wr_cnt    = '0;
          nxt_wr_state  = tcc_pkg::TCC_WR_PULSE;
        end
      end
      tcc_pkg::TCC_WR_PULSE: begin
        nxt_wr_cnt = wr_cnt_ff + NW'(1);
        if (wr_cnt_ff == cnt_last(WR_PULSE_CYC)) begin
          nxt_wr_pulse = 1'b1;
          nxt_wr_state = tcc_pkg::TCC_WR_WAIT;
        end
      end
      tcc_pkg::TCC_WR_WAIT: begin
        nxt_wr_cnt = wr_cnt_ff + NW'(1);
        if (wr_cnt_ff == cnt_last(WR_SAMPLE_CYC)) begin
          if (miss_echo_ff && !i_echo) begin
            nxt_echo_err = 1'b1;
          end
          nxt_wr_state = tcc_pkg::TCC_WR_IDLE;
        end
      end
    endcase
    if (xfer_bad) begin
      nxt_x_perr = 1'b1;
    end
  end

  // General error gathers every check; a raise in the reset cycle wins.
  always_comb begin
    nxt_error = error_ff && !i_err_reset;
    if (nxt_hi_perr || nxt_x_perr || nxt_rc_err || nxt_lrc_err || nxt_echo_err) begin
      nxt_error = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rd_state_ff  <= tcc_pkg::TCC_RD_IDLE;
      wr_state_ff  <= tcc_pkg::TCC_WR_IDLE;
      rd_cnt_ff    <= '0;
      wr_cnt_ff    <= '0;
      hi_reg_ff    <= tcc_pkg::CHAR_ZERO;
      lo_reg_ff    <= tcc_pkg::CHAR_ZERO;
      xfer_ff      <= tcc_pkg::CHAR_ZERO;
      lrc_ff       <= tcc_pkg::CHAR_ZERO;
      is_check_ff  <= 1'b0;
      rd_valid_ff  <= 1'b0;
      wr_pulse_ff  <= 1'b0;
      miss_echo_ff <= 1'b0;
      hi_perr_ff   <= 1'b0;
      x_perr_ff    <= 1'b0;
      rc_err_ff    <= 1'b0;
      lrc_err_ff   <= 1'b0;
      echo_err_ff  <= 1'b0;
      error_ff     <= 1'b0;
    end else begin
      rd_state_ff  <= nxt_rd_state;
      wr_state_ff  <= nxt_wr_state;
      rd_cnt_ff    <= nxt_rd_cnt;
      wr_cnt_ff    <= nxt_wr_cnt;
      hi_reg_ff    <= nxt_hi_reg;
      lo_reg_ff    <= nxt_lo_reg;
      xfer_ff      <= nxt_xfer;
      lrc_ff       <= nxt_lrc;
      is_check_ff  <= nxt_is_check;
      rd_valid_ff  <= nxt_rd_valid;
      wr_pulse_ff  <= nxt_wr_pulse;
      miss_echo_ff <= nxt_miss_echo;
      hi_perr_ff   <= nxt_hi_perr;
      x_perr_ff    <= nxt_x_perr;
      rc_err_ff    <= nxt_rc_err;
      lrc_err_ff   <= nxt_lrc_err;
      echo_err_ff  <= nxt_echo_err;
      error_ff     <= nxt_error;
    end
  end

  assign o_rd_data         = xfer_ff;
  assign o_wr_bus          = xfer_ff;
  assign o_rd_valid        = rd_valid_ff;
  assign o_wr_pulse        = wr_pulse_ff;
  assign o_lrc_stages      = lrc_ff;
  assign o_hi_parity_err   = hi_perr_ff;
  assign o_xfer_parity_err = x_perr_ff;
  assign o_read_cycle_err  = rc_err_ff;
  assign o_lrc_err         = lrc_err_ff;
  assign o_missing_echo    = miss_echo_ff;
  assign o_echo_err        = echo_err_ff;
  assign o_error           = error_ff;

endmodule : tcc_datapath

`default_nettype wire

// File: dv/tcc_drive_model.sv
// Behavioural tape drive: answers each write pulse with an echo pulse.
// Assumes the bench gates the echo to provoke a missing echo on purpose.
`timescale 1ns/10ps
`default_nettype none
module tcc_drive_model (
  input  wire logic i_sys_clk,
  input  wire logic i_wr_pulse,
  input  wire logic i_echo_en,
  output logic      o_echo
);
  // The echo comes a few cycles late, as real write circuits take time to respond.
  logic [2:0] dly_ff = 3'h0;
  always @(posedge i_sys_clk) begin
    dly_ff <= {dly_ff[1:0], i_wr_pulse & i_echo_en};
  end
  assign o_echo = dly_ff[2];
endmodule : tcc_drive_model
`default_nettype wire

// File: dv/tcc_datapath_asserts.sv
// Port checker for the tape character datapath.
// Assumes it is bound onto tcc_datapath with the same timing parameters.
`timescale 1ns/10ps
`default_nettype none
module tcc_datapath_asserts #(
  parameter int unsigned ACCUM_CYC      = 4,
  parameter int unsigned LRC_SAMPLE_CYC = 2,
  parameter int unsigned WR_PULSE_CYC   = 2,
  parameter int unsigned WR_SAMPLE_CYC  = 6
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_b,
  input wire logic       i_err_reset,
  input wire logic       i_read_start,
  input wire logic       i_wr_char_valid,
  input wire logic       i_echo,
  input wire logic [6:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic       o_wr_pulse,
  input wire logic [6:0] o_lrc_stages,
  input wire logic       o_lrc_err,
  input wire logic       o_missing_echo,
  input wire logic       o_echo_err,
  input wire logic       o_error
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_drop_valid;
    ##1 !o_rd_valid;
  endsequence
  sequence s_drop_pulse;
    ##1 !o_wr_pulse;
  endsequence
  a_valid_one_cycle: assert property (o_rd_valid |-> s_drop_valid)
    else $error("read valid longer than one cycle");
  a_pulse_one_cycle: assert property (o_wr_pulse |-> s_drop_pulse)
    else $error("write pulse longer than one cycle");
  a_pulse_after_flag: assert property ($rose(o_wr_pulse) |-> $past(o_missing_echo))
    else $error("write pulse without missing echo flag");
  a_echo_clears_flag: assert property (i_echo && !i_wr_char_valid |=> !o_missing_echo)
    else $error("echo did not clear missing echo flag");
  a_echo_err_cause: assert property ($rose(o_echo_err) |-> $past(o_missing_echo) && o_error)
    else $error("echo error without missing echo");
  a_error_sticky: assert property (o_error && !i_err_reset |=> o_error)
    else $error("error flag dropped without reset");
  a_lrc_start_clear: assert property (i_read_start |=> o_lrc_stages == 7'h00)
    else $error("longitudinal stages not cleared");
  a_lrc_toggle: assert property (o_rd_valid |-> o_lrc_stages == ($past(o_lrc_stages) ^ o_rd_data))
    else $error("longitudinal stages did not toggle");
  a_lrc_err_cause: assert property ($rose(o_lrc_err) |-> o_lrc_stages != 7'h00 && o_error)
    else $error("longitudinal error with clear stages");
  a_rd_data_hold: assert property ($changed(o_rd_data) |-> o_rd_valid || $past(i_wr_char_valid))
    else $error("transfer register changed without load");
endmodule : tcc_datapath_asserts
bind tcc_datapath tcc_datapath_asserts #(
  .ACCUM_CYC(ACCUM_CYC), .LRC_SAMPLE_CYC(LRC_SAMPLE_CYC),
  .WR_PULSE_CYC(WR_PULSE_CYC), .WR_SAMPLE_CYC(WR_SAMPLE_CYC)
) i_asserts (
  .i_sys_clk       (i_sys_clk),
  .i_rst_b         (i_rst_b),
  .i_err_reset     (i_err_reset),
  .i_read_start    (i_read_start),
  .i_wr_char_valid (i_wr_char_valid),
  .i_echo          (i_echo),
  .o_rd_data       (o_rd_data),
  .o_rd_valid      (o_rd_valid),
  .o_wr_pulse      (o_wr_pulse),
  .o_lrc_stages    (o_lrc_stages),
  .o_lrc_err       (o_lrc_err),
  .o_missing_echo  (o_missing_echo),
  .o_echo_err      (o_echo_err),
  .o_error         (o_error)
);
`default_nettype wire

// File: dv/tcc_datapath_tb.sv
// Self-checking bench for the tape character datapath: reads, check characters, writes.
// Assumes shortened timing counts 4, 2, 2 and 6; inputs change on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tcc_datapath_tb;
  logic       i_sys_clk = 0, i_rst_b = 0, i_err_reset = 0, i_odd_sense = 0;
  logic       i_read_start = 0, i_readback_mode = 0, i_check_char = 0, i_wr_char_valid = 0;
  logic [6:0] i_hi_bits = '0, i_lo_bits = '0, i_wr_char = '0;
  logic       i_echo, echo_en = 1;
  logic [6:0] o_rd_data, o_wr_bus, o_lrc_stages;
  logic       o_rd_valid, o_wr_pulse, o_hi_parity_err, o_xfer_parity_err, o_read_cycle_err;
  logic       o_lrc_err, o_missing_echo, o_echo_err, o_error;
  int         num_errors = 0, tests_run = 0, n_valid = 0, n_pulse = 0;
  tcc_datapath #(.ACCUM_CYC(4), .LRC_SAMPLE_CYC(2), .WR_PULSE_CYC(2), .WR_SAMPLE_CYC(6)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_err_reset(i_err_reset), .i_odd_sense(i_odd_sense),
    .i_read_start(i_read_start), .i_readback_mode(i_readback_mode), .i_hi_bits(i_hi_bits),
    .i_lo_bits(i_lo_bits), .i_check_char(i_check_char), .i_wr_char_valid(i_wr_char_valid),
    .i_wr_char(i_wr_char), .i_echo(i_echo), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_wr_bus(o_wr_bus), .o_wr_pulse(o_wr_pulse), .o_lrc_stages(o_lrc_stages),
    .o_hi_parity_err(o_hi_parity_err), .o_xfer_parity_err(o_xfer_parity_err),
    .o_read_cycle_err(o_read_cycle_err), .o_lrc_err(o_lrc_err), .o_missing_echo(o_missing_echo),
    .o_echo_err(o_echo_err), .o_error(o_error)
  );
  tcc_drive_model i_drive (.i_sys_clk(i_sys_clk), .i_wr_pulse(o_wr_pulse), .i_echo_en(echo_en), .o_echo(i_echo));
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    n_valid += (o_rd_valid === 1'b1);
    n_pulse += (o_wr_pulse === 1'b1);
  end
  task automatic chk(string n, logic [6:0] e, logic [6:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test;
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic pulse(ref logic s);
    @(negedge i_sys_clk);
    s = 1;
    @(negedge i_sys_clk);
    s = 0;
    @(negedge i_sys_clk);
  endtask : pulse
  // Check character level is held past the window so a slow capture still sees it.
  task automatic send_char(logic [6:0] hi, logic [6:0] lo, logic cc);
    @(negedge i_sys_clk);
    i_hi_bits = hi;
    i_lo_bits = lo;
    i_check_char = cc;
    @(negedge i_sys_clk);
    i_hi_bits = '0;
    i_lo_bits = '0;
    repeat (9) @(negedge i_sys_clk);
    i_check_char = 0;
  endtask : send_char
  task automatic write_char(logic [6:0] c);
    @(negedge i_sys_clk);
    i_wr_char = c;
    i_wr_char_valid = 1;
    @(negedge i_sys_clk);
    i_wr_char_valid = 0;
    chk("wr_bus", c, o_wr_bus);
    chk("missing_echo", 7'h01, 7'(o_missing_echo));
    repeat (12) @(negedge i_sys_clk);
  endtask : write_char
  task automatic t_read;
    pulse(i_read_start);
    chk("lrc_start", 7'h00, o_lrc_stages);
    send_char(7'h03, 7'h03, 0);
    chk("rd_data", 7'h03, o_rd_data);
    chk("cycle_err", 7'h00, 7'(o_read_cycle_err));
    send_char(7'h05, 7'h05, 0);
    chk("lrc", 7'h06, o_lrc_stages);
    send_char(7'h07, 7'h06, 0);
    chk("rd_fallback", 7'h06, o_rd_data);
    chk("hi_parity", 7'h01, 7'(o_hi_parity_err));
    chk("cycle_err_set", 7'h01, 7'(o_read_cycle_err));
    chk("lrc_sel", 7'h00, o_lrc_stages);
    chk("valid_count", 7'h03, 7'(n_valid));
    pulse(i_err_reset);
    chk("err_clear", 7'h00, 7'(o_error));
  endtask : t_read
  task automatic t_check_char;
    pulse(i_read_start);
    send_char(7'h0c, 7'h0c, 0);
    send_char(7'h0c, 7'h0c, 1);
    chk("lrc_even", 7'h00, 7'(o_lrc_err));
    send_char(7'h05, 7'h05, 1);
    chk("lrc_odd", 7'h01, 7'(o_lrc_err));
    chk("lrc_error", 7'h01, 7'(o_error));
    pulse(i_err_reset);
  endtask : t_check_char
  task automatic t_readback;
    i_readback_mode = 1;
    send_char(7'h06, 7'h06, 0);
    chk("rb_rd_data", 7'h05, o_rd_data);
    chk("rb_lrc", 7'h03, o_lrc_stages);
    chk("rb_valid", 7'h06, 7'(n_valid));
    i_readback_mode = 0;
  endtask : t_readback
  task automatic t_write;
    write_char(7'h0a);
    chk("echo_ok", 7'h00, 7'(o_echo_err));
    echo_en = 0;
    write_char(7'h0c);
    chk("echo_err", 7'h01, 7'(o_echo_err));
    chk("error", 7'h01, 7'(o_error));
    chk("pulses", 7'h02, 7'(n_pulse));
    repeat (5) @(negedge i_sys_clk);
    chk("sticky", 7'h01, 7'(o_echo_err));
    echo_en = 1;
    pulse(i_err_reset);
    chk("echo_clear", 7'h00, 7'(o_echo_err));
  endtask : t_write
  task automatic t_odd;
    i_odd_sense = 1;
    pulse(i_read_start);
    send_char(7'h07, 7'h07, 0);
    pulse(i_err_reset);
    chk("odd_hi", 7'h00, 7'(o_hi_parity_err));
    chk("odd_xfer", 7'h00, 7'(o_xfer_parity_err));
    send_char(7'h03, 7'h03, 0);
    chk("odd_hi_bad", 7'h01, 7'(o_hi_parity_err));
    chk("odd_xfer_bad", 7'h01, 7'(o_xfer_parity_err));
    i_odd_sense = 0;
  endtask : t_odd
  initial begin
    repeat (2) @(negedge i_sys_clk);
    i_rst_b = 1;
    chk("reset_err", 7'h00, 7'(o_error));
    t_read;
    t_check_char;
    t_readback;
    t_write;
    t_odd;
    stop_test;
  end
  // The whole run needs under two hundred cycles; five thousand means a hang.
  initial begin
    #25000;
    num_errors++;
    stop_test;
  end
endmodule : tcc_datapath_tb
`default_nettype wire
